//--- rtl/smc_pkg.sv
// constants for the accelerometer mode and control register bank
// assumes a byte-wide register port driven by the serial protocol engine
//
// Overview of operation
// RL1 - Bit 7 of the speed/polarity/range register picks high speed (1) or fast (0) bus mode and resets to 1.
// RL2 - Bit 6 sets both interrupt pins active low (0, reset) or active high (1).
// RL3 - The two-bit range field selects 2 g (01), 4 g (10) or 8 g (11), and the register resets to 0x81.
// RL4 - With the ready-output disable bit (power control bit 2) set, the sample ready pin is held at 0.
// RL5 - The temperature disable bit (power control bit 1) or standby stops temperature processing.
// RL6 - The standby bit (power control bit 0) resets to 1 and halts both datapaths; writing 0 starts measurement.
// RL7 - Entering standby resets the digital functions, FIFO pointers among them.
// RL8 - The host changes configuration only in standby, except the high-pass filter setting.
// RL9 - A high-pass filter setting change is accepted and applied while measuring.
// RL10 - Self test register bit 0 enables self test mode and resets to 0.
// RL11 - Self test register bit 1 applies the self test force and resets to 0.
// RL12 - Writing 0x52 to the write-only soft reset register resets the device like power-on.
// RL13 - After power-on or soft reset the factory store is loaded into shadow registers used by the logic.
// RL14 - The host should read shadow registers 0x50 to 0x54 after power-up and keep them as reference.
// RL15 - After each soft reset the host should re-read them and reset again until they match.
// RL16 - Reserved bits read as zero and ignore writes.

package smc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_RANGE = 8'h2c;
  localparam logic [7:0] ADDR_POWER = 8'h2d;
  localparam logic [7:0] ADDR_SELF = 8'h2e;
  localparam logic [7:0] ADDR_SRST = 8'h2f;
  localparam logic [7:0] ADDR_SHADOW_FIRST = 8'h50;
  localparam logic [7:0] ADDR_SHADOW_LAST = 8'h54;
  localparam int SHADOW_COUNT = 5;

  // reset values and the soft reset code
  localparam logic [7:0] RST_RANGE = 8'h81;
  localparam logic [7:0] RST_POWER = 8'h01;
  localparam logic [7:0] RST_SELF = 8'h00;
  localparam logic [2:0] RST_HPF = 3'h0;
  localparam logic [7:0] SRST_CODE = 8'h52;

  // writable bits; everything else is reserved
  localparam logic [7:0] MASK_RANGE = 8'hc3;
  localparam logic [7:0] MASK_POWER = 8'h07;
  localparam logic [7:0] MASK_SELF = 8'h03;

  // field positions
  localparam int BIT_BUS_SPEED = 7;
  localparam int BIT_IRQ_POL = 6;
  localparam int RANGE_LSB = 0;
  localparam int BIT_READY_OFF = 2;
  localparam int BIT_TEMP_OFF = 1;
  localparam int BIT_STANDBY = 0;
  localparam int BIT_ST_MODE = 0;
  localparam int BIT_ST_FORCE = 1;

  typedef enum logic {LD_IDLE, LD_FETCH} smc_load_state_t;
endpackage

//--- rtl/smc_link_if.sv
// carrier between the register bank, the shadow loader and the pin stage
// assumes all three sit on the one system clock
`timescale 1ns/1ps
`default_nettype none

interface smc_link_if;
  logic start;
  logic busy;
  logic [2:0] rd_idx;
  logic [7:0] rd_byte;
  logic irq_polarity;
  logic ready_off;
  logic standby;

  modport ctl (output start, rd_idx, irq_polarity, ready_off, standby, input busy, rd_byte);
  modport loader (input start, rd_idx, output busy, rd_byte);
  modport gate (input irq_polarity, ready_off, standby);
endinterface

`default_nettype wire

//--- rtl/smc_shadow_loader.sv
// copies the factory store into the shadow registers after power-on or soft reset
// assumes the factory store answers combinationally in the cycle of the read strobe
`timescale 1ns/1ps
`default_nettype none

module smc_shadow_loader #(
  parameter int COUNT = smc_pkg::SHADOW_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  smc_link_if.loader link,
  output logic [2:0] factory_addr_o,
  output logic factory_rd_o,
  input wire logic [7:0] factory_data_i
);
  smc_pkg::smc_load_state_t state, next_state;
  logic [7:0] shadow [COUNT];
  logic [7:0] next_shadow [COUNT];
  logic [2:0] idx, next_idx;
  logic pending, next_pending;
  logic busy, next_busy;
  logic rd, next_rd;

  assign link.busy = busy;
  assign link.rd_byte = (int'(link.rd_idx) < COUNT) ? shadow[link.rd_idx] : 8'h00;
  assign factory_addr_o = idx;
  assign factory_rd_o = rd;

  always_comb begin
    next_state = state;
    next_shadow = shadow;
    next_idx = idx;
    next_pending = pending | link.start;
    next_busy = busy;
    next_rd = 1'b0;
    unique case (state)
      smc_pkg::LD_IDLE: begin
        // power-on leaves pending set so the first edges load the store
        if (next_pending) begin
          next_state = smc_pkg::LD_FETCH;
          next_idx = 3'h0;
          next_pending = 1'b0;
          next_busy = 1'b1;
          next_rd = 1'b1;
        end
      end
      smc_pkg::LD_FETCH: begin
        // RL13 shadow byte capture
        next_shadow[idx] = factory_data_i;
        if (int'(idx) == COUNT - 1) begin
          if (next_pending) begin
            // a soft reset taken during the load starts a fresh pass with no idle gap
            next_idx = 3'h0;
            next_pending = 1'b0;
            next_rd = 1'b1;
          end else begin
            next_state = smc_pkg::LD_IDLE;
            next_busy = 1'b0;
          end
        end else begin
          next_idx = idx + 3'h1;
          next_rd = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= smc_pkg::LD_IDLE;
      idx <= 3'h0;
      pending <= 1'b1;
      busy <= 1'b0;
      rd <= 1'b0;
      for (int i = 0; i < COUNT; i++) begin
        shadow[i] <= 8'h00;
      end
    end else begin
      state <= next_state;
      idx <= next_idx;
      pending <= next_pending;
      busy <= next_busy;
      rd <= next_rd;
      shadow <= next_shadow;
    end
  end

  a_shadow_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL13
    (state == smc_pkg::LD_FETCH) |=> shadow[$past(idx)] == $past(factory_data_i))
    else $error("shadow byte not taken from factory store");

  a_load_length: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL13
    (state == smc_pkg::LD_IDLE && next_state == smc_pkg::LD_FETCH && !link.start) ##1 !link.start [*5]
      |=> !busy)
    else $error("shadow load did not finish in five cycles");
endmodule

`default_nettype wire

//--- rtl/smc_pin_gate.sv
// drives the interrupt and sample ready pins from internal active-high events
// assumes the event inputs are synchronous single-clock levels
`timescale 1ns/1ps
`default_nettype none

module smc_pin_gate (
  input wire logic clk_i,
  input wire logic rst_n_i,
  smc_link_if.gate link,
  input wire logic irq_one_i,
  input wire logic irq_two_i,
  input wire logic data_ready_i,
  output logic irq_line_one_o,
  output logic irq_line_two_o,
  output logic sample_ready_pin_o
);
  logic next_one, next_two, next_ready;

  always_comb begin
    // RL2 pin polarity
    next_one = irq_one_i ~^ link.irq_polarity;
    next_two = irq_two_i ~^ link.irq_polarity;
    // RL4 ready pin forced low
    next_ready = data_ready_i & ~link.ready_off & ~link.standby;
  end

  // reset polarity is active low, so idle interrupt pins start high and the sample ready pin starts low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_line_one_o <= 1'b1;
      irq_line_two_o <= 1'b1;
      sample_ready_pin_o <= 1'b0;
    end else begin
      irq_line_one_o <= next_one;
      irq_line_two_o <= next_two;
      sample_ready_pin_o <= next_ready;
    end
  end

  a_irq_polarity: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL2
    1'b1 |=> irq_line_one_o == ($past(irq_one_i) ~^ $past(link.irq_polarity))
      && irq_line_two_o == ($past(irq_two_i) ~^ $past(link.irq_polarity)))
    else $error("interrupt pin polarity wrong");

  a_ready_forced: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL4
    (link.ready_off || link.standby) |=> !sample_ready_pin_o)
    else $error("sample ready pin not held low");
endmodule

`default_nettype wire

//--- rtl/smc_regs.sv
// mode and control register bank of the accelerometer
// assumes the serial engine gives one-cycle read and write strobes with address and data
`timescale 1ns/1ps
`default_nettype none

module smc_regs (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // high-pass filter setting from its own register
  input wire logic HPF_WR_I,
  input wire logic [2:0] HPF_CODE_I,
  output logic [2:0] HPF_CODE_O,
  // configuration towards the sensor
  output logic BUS_SPEED_SELECT_O,
  output logic IRQ_POLARITY_O,
  output logic [1:0] RANGE_O,
  output logic STANDBY_O,
  output logic ACCEL_ENABLE_O,
  output logic TEMP_ENABLE_O,
  output logic DIGITAL_RESET_O,
  output logic SELFTEST_MODE_ENABLE_O,
  output logic SELFTEST_FORCE_ENABLE_O,
  // factory store and shadow load
  output logic [2:0] FACTORY_ADDR_O,
  output logic FACTORY_RD_O,
  input wire logic [7:0] FACTORY_DATA_I,
  output logic LOAD_BUSY_O,
  // pins
  input wire logic IRQ_ONE_EVENT_I,
  input wire logic IRQ_TWO_EVENT_I,
  input wire logic DATA_READY_I,
  output logic IRQ_LINE_ONE_O,
  output logic IRQ_LINE_TWO_O,
  output logic SAMPLE_READY_PIN_O
);
  smc_link_if link ();

  logic [7:0] reg_range, next_range;
  logic [7:0] reg_power, next_power;
  logic [7:0] reg_self, next_self;
  logic [2:0] hpf, next_hpf;
  logic soft_req, next_soft_req;
  logic temp_en, next_temp_en;
  logic accel_en, next_accel_en;
  logic dig_rst, next_dig_rst;
  logic [7:0] rdata, next_rdata;
  logic rvalid, next_rvalid;

  assign BUS_SPEED_SELECT_O = reg_range[smc_pkg::BIT_BUS_SPEED];
  assign IRQ_POLARITY_O = reg_range[smc_pkg::BIT_IRQ_POL];
  assign RANGE_O = reg_range[smc_pkg::RANGE_LSB +: 2];
  assign STANDBY_O = reg_power[smc_pkg::BIT_STANDBY];
  assign ACCEL_ENABLE_O = accel_en;
  assign TEMP_ENABLE_O = temp_en;
  assign DIGITAL_RESET_O = dig_rst;
  assign SELFTEST_MODE_ENABLE_O = reg_self[smc_pkg::BIT_ST_MODE];
  assign SELFTEST_FORCE_ENABLE_O = reg_self[smc_pkg::BIT_ST_FORCE];
  assign HPF_CODE_O = hpf;
  assign REG_RDATA_O = rdata;
  assign REG_RVALID_O = rvalid;
  assign LOAD_BUSY_O = link.busy;

  assign link.start = soft_req;
  assign link.rd_idx = 3'(REG_ADDR_I - smc_pkg::ADDR_SHADOW_FIRST);
  assign link.irq_polarity = reg_range[smc_pkg::BIT_IRQ_POL];
  assign link.ready_off = reg_power[smc_pkg::BIT_READY_OFF];
  assign link.standby = reg_power[smc_pkg::BIT_STANDBY];

  // register writes; the bank never blocks a write in measurement mode,
  // keeping configuration still while measuring is left to the host
  always_comb begin
    next_range = reg_range;
    next_power = reg_power;
    next_self = reg_self;
    next_hpf = hpf;
    next_soft_req = 1'b0;
    if (soft_req) begin
      // RL12 soft reset restores power-on values
      next_range = smc_pkg::RST_RANGE;
      next_power = smc_pkg::RST_POWER;
      next_self = smc_pkg::RST_SELF;
      next_hpf = smc_pkg::RST_HPF;
    end else begin
      if (REG_WR_I) begin
        unique case (REG_ADDR_I)
          // RL1 RL2 RL3 speed polarity range
          smc_pkg::ADDR_RANGE: next_range = REG_WDATA_I & smc_pkg::MASK_RANGE;
          // RL6 standby and measurement
          smc_pkg::ADDR_POWER: next_power = REG_WDATA_I & smc_pkg::MASK_POWER;
          // RL10 RL11 self test bits
          smc_pkg::ADDR_SELF: next_self = REG_WDATA_I & smc_pkg::MASK_SELF;
          // RL12 reset code check
          smc_pkg::ADDR_SRST: next_soft_req = (REG_WDATA_I == smc_pkg::SRST_CODE);
          default: begin
          end
        endcase
      end
      // RL9 filter change applies in any mode
      if (HPF_WR_I) begin
        next_hpf = HPF_CODE_I;
      end
    end
  end

  // derived controls, registered so the outputs come from flops
  always_comb begin
    // RL5 temperature stop
    next_temp_en = ~next_power[smc_pkg::BIT_STANDBY] & ~next_power[smc_pkg::BIT_TEMP_OFF];
    // RL6 measurement enable kept in its own flop
    next_accel_en = ~next_power[smc_pkg::BIT_STANDBY];
    // RL7 digital functions held reset in standby
    next_dig_rst = next_power[smc_pkg::BIT_STANDBY] | soft_req;
  end

  // reads; reserved bits are zero in storage, write-only and unmapped read zero
  always_comb begin
    next_rvalid = REG_RD_I;
    next_rdata = rdata;
    if (REG_RD_I) begin
      if (REG_ADDR_I >= smc_pkg::ADDR_SHADOW_FIRST && REG_ADDR_I <= smc_pkg::ADDR_SHADOW_LAST) begin
        // RL14 shadow registers visible to the host
        next_rdata = link.rd_byte;
      end else begin
        unique case (REG_ADDR_I)
          smc_pkg::ADDR_RANGE: next_rdata = reg_range;
          smc_pkg::ADDR_POWER: next_rdata = reg_power;
          smc_pkg::ADDR_SELF: next_rdata = reg_self;
          // RL16 reserved and write-only read zero
          default: next_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      reg_range <= smc_pkg::RST_RANGE;
      reg_power <= smc_pkg::RST_POWER;
      reg_self <= smc_pkg::RST_SELF;
      hpf <= smc_pkg::RST_HPF;
      soft_req <= 1'b0;
    end else begin
      reg_range <= next_range;
      reg_power <= next_power;
      reg_self <= next_self;
      hpf <= next_hpf;
      soft_req <= next_soft_req;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      temp_en <= 1'b0;
      accel_en <= 1'b0;
      dig_rst <= 1'b1;
    end else begin
      temp_en <= next_temp_en;
      accel_en <= next_accel_en;
      dig_rst <= next_dig_rst;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  smc_shadow_loader #(
    .COUNT(smc_pkg::SHADOW_COUNT)
  ) u_loader (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .link(link.loader),
    .factory_addr_o(FACTORY_ADDR_O),
    .factory_rd_o(FACTORY_RD_O),
    .factory_data_i(FACTORY_DATA_I)
  );

  smc_pin_gate u_pins (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .link(link.gate),
    .irq_one_i(IRQ_ONE_EVENT_I),
    .irq_two_i(IRQ_TWO_EVENT_I),
    .data_ready_i(DATA_READY_I),
    .irq_line_one_o(IRQ_LINE_ONE_O),
    .irq_line_two_o(IRQ_LINE_TWO_O),
    .sample_ready_pin_o(SAMPLE_READY_PIN_O)
  );

  a_range_write: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL3
    (REG_WR_I && REG_ADDR_I == smc_pkg::ADDR_RANGE && !soft_req)
      |=> RANGE_O == $past(REG_WDATA_I[1:0]) && BUS_SPEED_SELECT_O == $past(REG_WDATA_I[7])
        && IRQ_POLARITY_O == $past(REG_WDATA_I[6]))
    else $error("range register write not applied");

  a_soft_defaults: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL12
    soft_req |=> reg_range == 8'h81 && reg_power == 8'h01 && reg_self == 8'h00 && BUS_SPEED_SELECT_O)
    else $error("soft reset did not restore defaults");

  a_soft_code: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL12
    (REG_WR_I && REG_ADDR_I == smc_pkg::ADDR_SRST && !soft_req) |=> soft_req == ($past(REG_WDATA_I) == 8'h52))
    else $error("soft reset code decode wrong");

  a_soft_reload: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL13
    soft_req |=> LOAD_BUSY_O && DIGITAL_RESET_O)
    else $error("soft reset did not start shadow load");

  a_temp_stop: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL5
    (reg_power[smc_pkg::BIT_STANDBY] || reg_power[smc_pkg::BIT_TEMP_OFF]) |-> !TEMP_ENABLE_O)
    else $error("temperature processing not stopped");

  a_standby_halt: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL6
    (REG_WR_I && REG_ADDR_I == smc_pkg::ADDR_POWER && !soft_req)
      |=> STANDBY_O == $past(REG_WDATA_I[0]) && ACCEL_ENABLE_O == !$past(REG_WDATA_I[0]))
    else $error("standby control not applied");

  a_enter_standby: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL7
    $rose(STANDBY_O) |-> DIGITAL_RESET_O ##1 DIGITAL_RESET_O || !STANDBY_O)
    else $error("digital reset missing on standby entry");

  a_hpf_measure: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL9
    (HPF_WR_I && !soft_req) |=> HPF_CODE_O == $past(HPF_CODE_I))
    else $error("filter setting not applied");

  a_selftest_bits: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL10
    (REG_WR_I && REG_ADDR_I == smc_pkg::ADDR_SELF && !soft_req)
      |=> SELFTEST_MODE_ENABLE_O == $past(REG_WDATA_I[0]) && SELFTEST_FORCE_ENABLE_O == $past(REG_WDATA_I[1]))
    else $error("self test bits not applied");

  a_reserved_zero: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL16
    (REG_RD_I && (REG_ADDR_I == smc_pkg::ADDR_RANGE || REG_ADDR_I == smc_pkg::ADDR_POWER
      || REG_ADDR_I == smc_pkg::ADDR_SELF || REG_ADDR_I == smc_pkg::ADDR_SRST))
      |=> REG_RVALID_O && (REG_RDATA_O & ~($past(REG_ADDR_I) == smc_pkg::ADDR_RANGE ? 8'hc3
        : $past(REG_ADDR_I) == smc_pkg::ADDR_POWER ? 8'h07
        : $past(REG_ADDR_I) == smc_pkg::ADDR_SELF ? 8'h03 : 8'h00)) == 8'h00)
    else $error("reserved bits read nonzero");

  a_read_answer: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL14
    REG_RD_I |=> REG_RVALID_O)
    else $error("read answer missing");

  a_read_quiet: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL14
    !REG_RD_I |=> !REG_RVALID_O)
    else $error("read answer without a read");

  a_shadow_read: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL14
    (REG_RD_I && REG_ADDR_I >= smc_pkg::ADDR_SHADOW_FIRST && REG_ADDR_I <= smc_pkg::ADDR_SHADOW_LAST)
      |=> REG_RDATA_O == $past(link.rd_byte))
    else $error("shadow register read wrong");

  a_srst_read: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL12
    (REG_RD_I && REG_ADDR_I == smc_pkg::ADDR_SRST) |=> REG_RDATA_O == 8'h00)
    else $error("write-only register read nonzero");

  a_config_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL16
    (!soft_req && !(REG_WR_I && (REG_ADDR_I == smc_pkg::ADDR_RANGE || REG_ADDR_I == smc_pkg::ADDR_POWER
      || REG_ADDR_I == smc_pkg::ADDR_SELF))) |=> $stable(reg_range) && $stable(reg_power) && $stable(reg_self))
    else $error("configuration changed without a write");

  a_power_mask: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL16
    (REG_WR_I && REG_ADDR_I == smc_pkg::ADDR_POWER && !soft_req) |=> reg_power == ($past(REG_WDATA_I) & 8'h07))
    else $error("power control reserved bits stored");

  a_reserved_store: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL16
    1'b1 |-> (reg_range & ~smc_pkg::MASK_RANGE) == 8'h00 && (reg_power & ~smc_pkg::MASK_POWER) == 8'h00
      && (reg_self & ~smc_pkg::MASK_SELF) == 8'h00)
    else $error("reserved bit stored");

  a_accel_follow: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL6
    1'b1 |-> ACCEL_ENABLE_O != STANDBY_O)
    else $error("acceleration enable disagrees with standby");

  a_temp_run: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL5
    (!reg_power[smc_pkg::BIT_STANDBY] && !reg_power[smc_pkg::BIT_TEMP_OFF]) |-> TEMP_ENABLE_O)
    else $error("temperature processing stopped while enabled");

  a_measure_release: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL7
    (!reg_power[smc_pkg::BIT_STANDBY] && !$past(soft_req)) |-> !DIGITAL_RESET_O)
    else $error("digital reset held while measuring");

  a_hpf_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL9
    (!HPF_WR_I && !soft_req) |=> $stable(HPF_CODE_O))
    else $error("filter setting changed without a write");

  a_soft_hpf: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL12
    soft_req |=> HPF_CODE_O == 3'h0)
    else $error("soft reset did not clear filter setting");

  a_soft_single: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL12
    soft_req |=> !soft_req)
    else $error("soft reset request longer than one cycle");

  a_ready_pass: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // RL4
    (!link.ready_off && !link.standby) |=> SAMPLE_READY_PIN_O == $past(DATA_READY_I))
    else $error("sample ready pin not following data ready");
endmodule

`default_nettype wire

//--- testbench/smc_factory_model.sv
// behavioural factory store for the shadow loader
// assumes one combinational byte per read strobe, index 0 to 4
`timescale 1ns/1ps
`default_nettype none

module smc_factory_model #(
  parameter logic [39:0] CONTENT = 40'h0
) (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [2:0] addr_i,
  output logic [7:0] data_o
);
  logic [7:0] held = 8'h00;
  logic hit;

  assign hit = rd_i && (addr_i < 3'h5);
  assign data_o = hit ? CONTENT[8 * addr_i +: 8] : ~held;

  // outside a strobe the bus shows the inverse of the last byte, so a late sample cannot pass
  always @(posedge clk_i) begin
    if (hit) begin
      held <= CONTENT[8 * addr_i +: 8];
    end
  end
endmodule

`default_nettype wire

//--- testbench/test_sensor_mode_control_regs.sv
// self-checking bench for the mode and control register bank
// assumes the one-cycle register strobes of the design and a combinational factory store
`timescale 1ns/1ps
`default_nettype none

module test_sensor_mode_control_regs;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r; logic [6:0] o;} smc_row_t;
  localparam logic [39:0] STORE = 40'h5a3ce1079b;
  // o = {speed, polarity, range, standby, force, mode}
  localparam smc_row_t ROWS [12] = '{
    '{8'h2c, 8'h42, 8'h42, 7'h34}, '{8'h2c, 8'hff, 8'hc3, 7'h7c}, '{8'h2c, 8'h02, 8'h02, 7'h14},
    '{8'h2c, 8'hc1, 8'hc1, 7'h6c}, '{8'h2c, 8'h81, 8'h81, 7'h4c}, '{8'h2e, 8'hfd, 8'h01, 7'h4d},
    '{8'h2e, 8'hfe, 8'h02, 7'h4e}, '{8'h2e, 8'h03, 8'h03, 7'h4f}, '{8'h2e, 8'h00, 8'h00, 7'h4c},
    '{8'h2f, 8'h11, 8'h00, 7'h4c}, '{8'h60, 8'hff, 8'h00, 7'h4c}, '{8'h2d, 8'hf9, 8'h01, 7'h4c}};
  // {written value, standby, accel, temp, digital reset, ready pin}
  localparam logic [12:0] PWR [5] = '{{8'h01, 5'h12}, {8'h00, 5'h0d}, {8'h04, 5'h0c}, {8'h02, 5'h09},
    {8'h03, 5'h12}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hpf_wr = 1'b0;
  logic [2:0] hpf_in = 3'h0;
  logic ev1 = 1'b0;
  logic ev2 = 1'b0;
  logic sample_ready_pin = 1'b0;
  logic [7:0] rdata, fdata;
  logic [2:0] hpf_out, faddr;
  logic [1:0] range;
  logic rvalid, speed, pol, standby, accel, temp, dig, st_mode, st_force, frd, busy, irq1, irq2, pin;
  int err_total = 0;
  int checks_done = 0;

  smc_regs DUT (.CLK_SYS_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .HPF_WR_I(hpf_wr),
    .HPF_CODE_I(hpf_in), .HPF_CODE_O(hpf_out), .BUS_SPEED_SELECT_O(speed), .IRQ_POLARITY_O(pol),
    .RANGE_O(range), .STANDBY_O(standby), .ACCEL_ENABLE_O(accel), .TEMP_ENABLE_O(temp),
    .DIGITAL_RESET_O(dig), .SELFTEST_MODE_ENABLE_O(st_mode), .SELFTEST_FORCE_ENABLE_O(st_force),
    .FACTORY_ADDR_O(faddr), .FACTORY_RD_O(frd), .FACTORY_DATA_I(fdata), .LOAD_BUSY_O(busy),
    .IRQ_ONE_EVENT_I(ev1), .IRQ_TWO_EVENT_I(ev2), .DATA_READY_I(sample_ready_pin), .IRQ_LINE_ONE_O(irq1),
    .IRQ_LINE_TWO_O(irq2), .SAMPLE_READY_PIN_O(pin));

  smc_factory_model #(.CONTENT(STORE)) u_store (.clk_i(clk), .rd_i(frd), .addr_i(faddr), .data_o(fdata));

  always #50 clk = ~clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({7'h00, rvalid}, 8'h01);
    d = rdata;
  endtask

  // entered before the load starts or in its first busy cycle; counts the cycles with busy high
  task automatic wait_load(output int cycles);
    int guard;
    cycles = 0;
    guard = 0;
    while (busy !== 1'b1 && guard < 10) begin
      @(negedge clk);
      guard++;
    end
    while (busy === 1'b1 && guard < 40) begin
      @(negedge clk);
      cycles++;
      guard++;
    end
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // the sequence needs under two hundred cycles; this is far beyond that
  initial begin
    #(5000 * 100);
    err_total++;
    report_and_stop();
  end

  initial begin
    logic [7:0] v;
    logic [7:0] ref_shadow [5];
    int cyc;
    int tries;
    logic match;
    repeat (2) @(negedge clk);
    chk({4'h0, irq1, irq2, busy, frd}, 8'h0c);
    rst_n = 1'b1;
    wait_load(cyc);
    chk(8'(cyc), 8'h05);
    chk({1'b0, speed, pol, range, standby, st_force, st_mode}, 8'h4c);
    chk({5'h00, accel, temp, dig}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      rd_reg(smc_pkg::ADDR_RANGE + 8'(i), v);
      chk(v, 8'(32'h81010000 >> (24 - 8 * i)));
    end
    for (int i = 0; i < smc_pkg::SHADOW_COUNT; i++) begin
      rd_reg(smc_pkg::ADDR_SHADOW_FIRST + 8'(i), ref_shadow[i]);
      chk(ref_shadow[i], STORE[8 * i +: 8]);
    end
    foreach (ROWS[i]) begin
      wr_reg(ROWS[i].a, ROWS[i].d);
      rd_reg(ROWS[i].a, v);
      chk(v, ROWS[i].r);
      chk({1'b0, speed, pol, range, standby, st_force, st_mode}, {1'b0, ROWS[i].o});
    end
    for (int p = 0; p < 2; p++) begin
      wr_reg(smc_pkg::ADDR_RANGE, {1'b1, p[0], 6'h01});
      for (int e = 0; e < 2; e++) begin
        @(negedge clk);
        ev1 = e[0];
        ev2 = ~e[0];
        repeat (2) @(negedge clk);
        chk({6'h00, irq1, irq2}, {6'h00, p[0] ? e[0] : ~e[0], p[0] ? ~e[0] : e[0]});
      end
    end
    wr_reg(smc_pkg::ADDR_RANGE, 8'h81);
    sample_ready_pin = 1'b1;
    foreach (PWR[i]) begin
      wr_reg(smc_pkg::ADDR_POWER, PWR[i][12:5]);
      repeat (2) @(negedge clk);
      chk({3'h0, standby, accel, temp, dig, pin}, {3'h0, PWR[i][4:0]});
      if (standby === 1'b0) begin
        @(negedge clk);
        hpf_in = 3'(i + 3);
        hpf_wr = 1'b1;
        @(negedge clk);
        hpf_wr = 1'b0;
        chk({5'h00, hpf_out}, 8'(i + 3));
      end
    end
    wr_reg(smc_pkg::ADDR_RANGE, 8'h42);
    wr_reg(smc_pkg::ADDR_SELF, 8'h03);
    tries = 0;
    do begin
      @(negedge clk);
      addr = smc_pkg::ADDR_SRST;
      wdata = smc_pkg::SRST_CODE;
      wr = 1'b1;
      @(negedge clk);
      addr = smc_pkg::ADDR_RANGE;
      wdata = 8'hff;
      @(negedge clk);
      wr = 1'b0;
      wait_load(cyc);
      chk(8'(cyc), 8'h05);
      match = 1'b1;
      for (int i = 0; i < smc_pkg::SHADOW_COUNT; i++) begin
        rd_reg(smc_pkg::ADDR_SHADOW_FIRST + 8'(i), v);
        chk(v, ref_shadow[i]);
        if (v !== ref_shadow[i]) begin
          match = 1'b0;
        end
      end
      tries++;
    end while (match !== 1'b1 && tries < 3);
    rd_reg(smc_pkg::ADDR_RANGE, v);
    chk(v, smc_pkg::RST_RANGE);
    rd_reg(smc_pkg::ADDR_SELF, v);
    chk(v, smc_pkg::RST_SELF);
    chk({5'h00, hpf_out}, 8'h00);
    chk({1'b0, speed, pol, range, standby, st_force, st_mode}, 8'h4c);
    chk({3'h0, standby, accel, temp, dig, pin}, 8'h12);
    report_and_stop();
  end
endmodule

`default_nettype wire
